// File: dv/host_serial_model.sv
// host side model driving the 4-wire serial write port
module host_serial_model (
	// clock
	input  wire logic clk_in,
	// level put on the data pin between frames
	input  wire logic tx_level_in,
	// serial port toward the device
	output logic      cs_out,
	output logic      sck_out,
	output logic      sdi_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic in_frame = 1'b0;
	logic frame_bit = 1'b0;
	logic cs_q = 1'b0;
	logic sck_q = 1'b0;
	// one process owns each pin; the task only moves these holding variables
	assign cs_out = cs_q;
	assign sck_out = sck_q;
	// outside frames the pin carries tx modulation or a changing pattern
	assign sdi_out = in_frame ? frame_bit : tx_level_in;
	task automatic send(input logic [15:0] frame, input int nbits, input int half);
		cs_q <= 1'b1;
		in_frame <= 1'b1;
		for (int i = 0; i < nbits; i++) begin
			frame_bit <= frame[15 - i];
			repeat (half) @(posedge clk_in);
			sck_q <= 1'b1;
			repeat (half) @(posedge clk_in);
			sck_q <= 1'b0;
		end
		repeat (half) @(posedge clk_in);
		cs_q <= 1'b0;
		in_frame <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : send
endmodule : host_serial_model

// File: dv/testbench.sv
// self-checking bench for the transceiver configuration registers
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, cs, sck, sdi, tx_level = 1'b0, hold = 1'b0;
	logic tx_pick = 1'b0, rx_mod = 1'b0, bit_ok = 1'b0, btn_n = 1'b1, pwr_on = 1'b0;
	logic ser_out, tx_mod, trans, irq, op_valid, band, manch, clk_pin;
	logic [2:0] op_mode;
	logic [12:0] word;
	int errors = 0, checks_done = 0;
	int mode_reg = 8'h80, low_reg = 8'hA8, high_reg = 8'h7B;
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) tx_level <= hold ? tx_pick : 1'($urandom);
	host_serial_model host_serial_model_inst (.clk_in(clk_in), .tx_level_in(tx_level),
		.cs_out(cs), .sck_out(sck), .sdi_out(sdi));
	transceiver_config_registers transceiver_config_registers_inst (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .spi_cs_in(cs), .spi_sck_in(sck),
		.serial_in_tx_mod_pin_in(sdi), .serial_out_rx_mod_pin_out(ser_out),
		.rx_mod_data_in(rx_mod), .tx_mod_data_out(tx_mod), .transparent_out(trans),
		.bit_check_ok_in(bit_ok), .power_button_n_in(btn_n), .power_on_status_in(pwr_on),
		.irq_bit_check_out(irq), .op_mode_out(op_mode), .op_valid_out(op_valid),
		.band_select_out(band), .manchester_on_out(manch), .rf_tuning_word_out(word),
		.clk_pin_out(clk_pin));
	task automatic compare(input string name, input logic [12:0] exp, input logic [12:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask : compare
	function automatic int exp_word();
		if (mode_reg[5]) return (high_reg >> 2) * 128 + (low_reg >> 1);
		return 3072 + ((high_reg >> 2) & 7) * 128 + (low_reg >> 1);
	endfunction : exp_word
	task automatic wr(input int addr, input int data);
		// link clock of 800 ns: four system clocks per half period
		host_serial_model_inst.send({1'b1, 2'b00, 5'(addr), 8'(data)}, 16, 4);
		if (addr == 0) mode_reg = data;
		if (addr == 1) low_reg = data;
		if (addr == 2) high_reg = data;
		repeat (4) @(posedge clk_in);
	endtask : wr
	task automatic check_all();
		int op, ones, zeros;
		op = (mode_reg >> 1) & 7;
		ones = 0;
		zeros = 0;
		@(negedge clk_in);
		compare("word", 13'(exp_word()), word);
		if (op != 4 && op != 6) compare("mode", 13'(op), {10'h0, op_mode});
		compare("valid", 13'(op != 4 && op != 6), {12'h0, op_valid});
		compare("band", 13'(mode_reg[4]), {12'h0, band});
		compare("transparent", 13'(mode_reg[0]), {12'h0, trans});
		compare("manchester", 13'(op == 1 && !low_reg[0]), {12'h0, manch});
		repeat (8) begin
			@(negedge clk_in);
			if (clk_pin === 1'b1) ones++;
			if (clk_pin === 1'b0) zeros++;
		end
		compare("clk_pin", 13'(high_reg[1] & high_reg[0]),
			(ones > 0 && zeros > 0) ? 13'h1 : (zeros == 8 ? 13'h0 : 13'h2));
		@(posedge clk_in);
	endtask : check_all
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (50000) @(posedge clk_in);
		errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'h8497));
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		check_all();
		for (int op = 0; op < 8; op++) begin
			wr(0, ($urandom & 8'h30) | (op << 1));
			wr(1, $urandom & 8'hFF);
			wr(2, $urandom & 8'hFF);
			check_all();
			bit_ok <= 1'b1;
			@(negedge clk_in);
			compare("irq", 13'((op == 2 || op == 3) && !low_reg[0]), {12'h0, irq});
			@(posedge clk_in);
			bit_ok <= 1'b0;
			if (op == 2 || op == 3) high_reg = high_reg | 1;
			repeat (4) @(posedge clk_in);
			check_all();
		end
		// refused frames: read flag, unmapped address, short count
		host_serial_model_inst.send({1'b0, 2'b00, 5'h01, 8'h00}, 16, 4);
		host_serial_model_inst.send({1'b1, 2'b00, 5'h05, 8'h00}, 16, 4);
		host_serial_model_inst.send({1'b1, 2'b00, 5'h01, 8'h00}, 15, 4);
		repeat (4) @(posedge clk_in);
		check_all();
		wr(2, (high_reg & 8'hFC) | 8'h02);
		check_all();
		btn_n <= 1'b0;
		repeat (3) @(posedge clk_in);
		btn_n <= 1'b1;
		high_reg = high_reg | 1;
		repeat (4) @(posedge clk_in);
		check_all();
		wr(2, (high_reg & 8'hFC) | 8'h02);
		pwr_on <= 1'b1;
		@(posedge clk_in);
		pwr_on <= 1'b0;
		high_reg = high_reg | 1;
		repeat (4) @(posedge clk_in);
		check_all();
		wr(2, high_reg & 8'hFD);
		check_all();
		wr(0, 8'h01);
		hold <= 1'b1;
		for (int v = 0; v < 4; v++) begin
			rx_mod <= v[0];
			tx_pick <= v[1];
			repeat (4) @(posedge clk_in);
			@(negedge clk_in);
			compare("serial_out", 13'(v & 1), {12'h0, ser_out});
			compare("tx_mod", 13'((v >> 1) & 1), {12'h0, tx_mod});
			@(posedge clk_in);
		end
		conclude();
	end
endmodule : testbench

// File: shared/xcvr_cfg_pkg.sv
// constants for the transceiver configuration register block
package xcvr_cfg_pkg;
	// register indices (serial address field)
	localparam logic [4:0] ADDR_MODE_BAND = 5'h00;
	localparam logic [4:0] ADDR_TUNE_LOW  = 5'h01;
	localparam logic [4:0] ADDR_TUNE_HIGH = 5'h02;
	// reset values
	localparam logic [7:0] RST_MODE_BAND = 8'h80;
	localparam logic [7:0] RST_TUNE_LOW  = 8'hA8;
	localparam logic [7:0] RST_TUNE_HIGH = 8'h7B;
	// mode_band_control fields
	localparam int POS_RANGE = 5;
	localparam int POS_BAND  = 4;
	localparam int POS_OP_HI = 3;
	localparam int POS_OP_LO = 1;
	localparam int POS_TRANS = 0;
	// rf_tuning_high_clock_out fields
	localparam int POS_HI_MSB  = 7;
	localparam int POS_HI_LSB  = 2;
	localparam int POS_NR_MSB  = 4;
	localparam int POS_CLK_EN  = 1;
	localparam int POS_CLK_ON  = 0;
	// tuning arithmetic
	localparam logic [12:0] TUNE_NARROW_BASE = 13'h0C00;
	localparam logic [12:0] TUNE_NARROW_MAX  = 13'h0FFF;
	localparam int          TUNE_STEP_SHIFT  = 7;
	localparam int          RF_STEP_DIVISOR  = 16384;
	// serial frame: 8 command bits then 8 data bits; command bit 7 set means write
	localparam int          FRAME_BITS = 16;
	localparam int          CMD_WRITE  = 15;
	// mode codes
	typedef enum logic [2:0] {
		OP_IDLE    = 3'h0,
		OP_TX      = 3'h1,
		OP_RX_POLL = 3'h2,
		OP_RX      = 3'h3,
		OP_FD_MST  = 3'h5,
		OP_FD_SLV  = 3'h7
	} op_mode_e;
	// clock output prescale (a half period in system clocks)
	localparam int CLK_OUT_HALF = 2;
endpackage : xcvr_cfg_pkg

// File: verilog/transceiver_config_registers.sv
// configuration registers of the transceiver with a 4-wire serial write port
module transceiver_config_registers (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// 4-wire serial port from the host
	input  wire logic        spi_cs_in,
	input  wire logic        spi_sck_in,
	input  wire logic        serial_in_tx_mod_pin_in,
	output logic             serial_out_rx_mod_pin_out,
	// data path
	input  wire logic        rx_mod_data_in,
	output logic             tx_mod_data_out,
	output logic             transparent_out,
	// events
	input  wire logic        bit_check_ok_in,
	input  wire logic        power_button_n_in,
	input  wire logic        power_on_status_in,
	output logic             irq_bit_check_out,
	// configuration outputs
	output logic [2:0]       op_mode_out,
	output logic             op_valid_out,
	output logic             band_select_out,
	output logic             manchester_on_out,
	output logic [12:0]      rf_tuning_word_out,
	output logic             clk_pin_out
);
	logic [7:0]  mode_band_control;
	logic [7:0]  rf_tuning_low;
	logic [7:0]  rf_tuning_high_clock_out;
	logic [2:0]  cs_sync;
	logic [2:0]  sck_sync;
	logic [1:0]  sdi_sync;
	logic [2:0]  btn_sync;
	logic [15:0] shift;
	logic [4:0]  bit_count;
	logic [12:0] applied_word;
	logic [2:0]  applied_mode;
	logic [1:0]  clk_div;
	logic        clk_phase;

	wire cs_active  = cs_sync[2];
	wire sck_rise   = sck_sync[1] & ~sck_sync[2];
	wire frame_end  = ~cs_sync[1] & cs_sync[2];
	wire frame_full = bit_count == 5'(xcvr_cfg_pkg::FRAME_BITS);
	wire is_write   = shift[xcvr_cfg_pkg::CMD_WRITE];
	wire [4:0] addr = shift[12:8];
	wire commit     = frame_end & frame_full & is_write;
	wire wr_mode    = commit & (addr == xcvr_cfg_pkg::ADDR_MODE_BAND);
	wire wr_low     = commit & (addr == xcvr_cfg_pkg::ADDR_TUNE_LOW);
	wire wr_high    = commit & (addr == xcvr_cfg_pkg::ADDR_TUNE_HIGH);
	wire range_full = mode_band_control[xcvr_cfg_pkg::POS_RANGE];
	wire [2:0] op   = mode_band_control[xcvr_cfg_pkg::POS_OP_HI:xcvr_cfg_pkg::POS_OP_LO];
	wire ctrl_lsb   = rf_tuning_low[0];
	wire rx_like    = (op == xcvr_cfg_pkg::OP_RX) | (op == xcvr_cfg_pkg::OP_RX_POLL);
	wire btn_event  = ~btn_sync[1] & btn_sync[2];

	// high part from the top tuning register, low part from bits 7..1 of the low one
	function automatic logic [12:0] tune_word(input logic full, input logic [7:0] hi,
			input logic [7:0] lo);
		logic [12:0] high;
		high = 13'h0000;
		if (full) begin
			high = 13'(hi[xcvr_cfg_pkg::POS_HI_MSB:xcvr_cfg_pkg::POS_HI_LSB])
				<< xcvr_cfg_pkg::TUNE_STEP_SHIFT;
		end else begin
			high = xcvr_cfg_pkg::TUNE_NARROW_BASE
				+ (13'(hi[xcvr_cfg_pkg::POS_NR_MSB:xcvr_cfg_pkg::POS_HI_LSB])
				<< xcvr_cfg_pkg::TUNE_STEP_SHIFT);
		end
		return high + 13'(lo[7:1]);
	endfunction : tune_word

	wire [12:0] next_word = tune_word(range_full, rf_tuning_high_clock_out, rf_tuning_low);
	// bit-level view of the same word, so the adder is checked against field placement
	wire [12:0] word_check = {range_full
		? rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_HI_MSB:xcvr_cfg_pkg::POS_HI_LSB]
		: {xcvr_cfg_pkg::TUNE_NARROW_BASE[12:10],
			rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_NR_MSB:xcvr_cfg_pkg::POS_HI_LSB]},
		rf_tuning_low[7:1]};
	// reset word follows the reset contents of both tuning registers in narrow range
	localparam logic [12:0] RST_WORD = xcvr_cfg_pkg::TUNE_NARROW_BASE
		+ (13'(xcvr_cfg_pkg::RST_TUNE_HIGH[xcvr_cfg_pkg::POS_NR_MSB:xcvr_cfg_pkg::POS_HI_LSB])
		<< xcvr_cfg_pkg::TUNE_STEP_SHIFT)
		+ 13'(xcvr_cfg_pkg::RST_TUNE_LOW[7:1]);

	// serial port and button synchronisers; stage 0 feeds stage 1 only
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cs_sync  <= 3'h0;
			sck_sync <= 3'h0;
			sdi_sync <= 2'h0;
			btn_sync <= 3'h7;
		end else begin
			cs_sync  <= {cs_sync[1:0], spi_cs_in};
			sck_sync <= {sck_sync[1:0], spi_sck_in};
			sdi_sync <= {sdi_sync[0], serial_in_tx_mod_pin_in};
			btn_sync <= {btn_sync[1:0], power_button_n_in};
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shift     <= 16'h0000;
			bit_count <= 5'h00;
		end else if (!cs_active) begin
			bit_count <= 5'h00;
		end else if (sck_rise && !frame_full) begin
			shift     <= {shift[14:0], sdi_sync[1]};
			bit_count <= bit_count + 5'h01;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_band_control <= xcvr_cfg_pkg::RST_MODE_BAND;
			rf_tuning_low     <= xcvr_cfg_pkg::RST_TUNE_LOW;
		end else begin
			if (wr_mode)
				mode_band_control <= shift[7:0];
			if (wr_low)
				rf_tuning_low <= shift[7:0];
		end
	end

	// event sets active bit, winning over a write
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rf_tuning_high_clock_out <= xcvr_cfg_pkg::RST_TUNE_HIGH;
		end else begin
			if (wr_high)
				rf_tuning_high_clock_out <= shift[7:0];
			if ((bit_check_ok_in && rx_like) || btn_event || power_on_status_in)
				rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_CLK_ON] <= 1'b1;
		end
	end

	// apply word and mode after commit
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			applied_word <= RST_WORD;
			applied_mode <= xcvr_cfg_pkg::OP_IDLE;
		end else begin
			applied_word <= next_word;
			applied_mode <= op;
		end
	end

	// clock divider gated by allow and active
	wire clk_run = rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_CLK_EN]
		& rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_CLK_ON];
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			clk_div   <= 2'h0;
			clk_phase <= 1'b0;
		end else if (!clk_run) begin
			clk_div   <= 2'h0;
			clk_phase <= 1'b0;
		end else if (clk_div == 2'(xcvr_cfg_pkg::CLK_OUT_HALF - 1)) begin
			clk_div   <= 2'h0;
			clk_phase <= ~clk_phase;
		end else begin
			clk_div <= clk_div + 2'h1;
		end
	end
	assign clk_pin_out = clk_phase;

	assign op_mode_out = applied_mode;
	assign op_valid_out = (applied_mode != 3'h4) & (applied_mode != 3'h6);
	assign band_select_out = mode_band_control[xcvr_cfg_pkg::POS_BAND];
	assign rf_tuning_word_out = applied_word;
	assign manchester_on_out = (applied_mode == xcvr_cfg_pkg::OP_TX) & ~ctrl_lsb;
	assign irq_bit_check_out = bit_check_ok_in & rx_like & ~ctrl_lsb;
	// transparent routing; while chip select is active the pins carry the port
	assign transparent_out = mode_band_control[xcvr_cfg_pkg::POS_TRANS];
	assign tx_mod_data_out = transparent_out & ~cs_active & sdi_sync[1];
	assign serial_out_rx_mod_pin_out = transparent_out & ~cs_active & rx_mod_data_in;

	a_narrow_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!$past(range_full) |-> (rf_tuning_word_out >= xcvr_cfg_pkg::TUNE_NARROW_BASE
		&& rf_tuning_word_out <= xcvr_cfg_pkg::TUNE_NARROW_MAX))
		else $error("tuning word outside narrow range");
	a_clk_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!clk_run |=> !clk_pin_out) else $error("clock pin ran while gated");
	a_event_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		power_on_status_in |=> rf_tuning_high_clock_out[xcvr_cfg_pkg::POS_CLK_ON])
		else $error("active bit not set by event");
	a_irq_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ctrl_lsb |-> !irq_bit_check_out) else $error("interrupt despite block bit");
	a_manch_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		manchester_on_out |-> applied_mode == xcvr_cfg_pkg::OP_TX)
		else $error("manchester outside transmit");
	a_mode_apply: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_mode |-> ##2 op_mode_out == $past(shift[3:1], 2)) else $error("mode not applied");
	a_trans_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!transparent_out |-> !tx_mod_data_out && !serial_out_rx_mod_pin_out)
		else $error("transparent path leaked");
	a_sum_word: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		##1 rf_tuning_word_out == $past(word_check)) else $error("tuning word mismatch");
	c_write_mode: cover property (@(posedge clk_in) wr_mode);
	c_write_high: cover property (@(posedge clk_in) wr_high);
	c_clock_wake: cover property (@(posedge clk_in) !clk_run ##1 clk_run);
	c_full_range: cover property (@(posedge clk_in) range_full && rf_tuning_word_out > 13'h1000);
endmodule : transceiver_config_registers
